// File: core/bfx_alu_if.sv
// operand and result bundle between the core and its datapath units
`timescale 1ns/1ps
interface bfx_alu_if;
  logic [7:0] opnd;
  logic carry_in;
  logic t_in;
  logic [2:0] bit_sel;
  logic [7:0] rol_res;
  logic [7:0] ror_res;
  logic rol_c;
  logic ror_c;
  logic [7:0] ins_res;
  logic [7:0] set_res;
  logic [7:0] clr_res;
  logic ext_bit;

  modport core (output opnd, carry_in, t_in, bit_sel,
                input rol_res, ror_res, rol_c, ror_c, ins_res, set_res, clr_res, ext_bit);
  modport rot (input opnd, carry_in, output rol_res, ror_res, rol_c, ror_c);
  modport bitu (input opnd, t_in, bit_sel, output ins_res, set_res, clr_res, ext_bit);
endinterface

// File: core/bfx_bitu.sv
// single-bit insert, force and extract datapath
`timescale 1ns/1ps
module bfx_bitu (
  bfx_alu_if.bitu alu
);
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      logic hit;
      assign hit = (alu.bit_sel == 3'(gi));
      assign alu.set_res[gi] = alu.opnd[gi] | hit; // RULE1
      assign alu.clr_res[gi] = alu.opnd[gi] & ~hit; // RULE2
      assign alu.ins_res[gi] = hit ? alu.t_in : alu.opnd[gi]; // RULE6
    end
  endgenerate
  assign alu.ext_bit = alu.opnd[alu.bit_sel]; // RULE5
endmodule // bfx_bitu

// File: core/bfx_defs.svh
// constants for the bit and flag operation executor
//
// Operation
// RULE1: an io force-one sets the chosen io bit, keeps the others and all flags, in two cycles.
// RULE2: an io force-zero clears the chosen io bit, keeps the others and all flags, in two cycles.
// RULE3: rotate left via carry moves bits up, fills bit 0 from carry, takes carry from bit 7.
// RULE4: rotate right via carry moves bits down, fills bit 7 from carry, takes carry from bit 0.
// RULE5: the reg-to-transfer copy puts the chosen register bit into the transfer flag only.
// RULE6: the transfer-to-reg copy puts the transfer flag into the chosen register bit only.
// RULE7: single-cycle operations set and clear the overflow flag and nothing else.
// RULE8: single-cycle operations set and clear the half-carry flag and nothing else.
// RULE9: single-cycle operations set and clear the signed-test flag and nothing else.
// RULE10: no operation touches flags outside its own set or any register but its target.
`ifndef BFX_DEFS_SVH
`define BFX_DEFS_SVH

// ----------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------
`define BFX_FLAG_C 3'd0
`define BFX_FLAG_Z 3'd1
`define BFX_FLAG_N 3'd2
`define BFX_FLAG_V 3'd3
`define BFX_FLAG_S 3'd4
`define BFX_FLAG_H 3'd5
`define BFX_FLAG_T 3'd6
`define BFX_FLAG_I 3'd7

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define BFX_IW_OP_HI 15
`define BFX_IW_OP_LO 12
`define BFX_IW_IO_HI 11
`define BFX_IW_RG_HI 10
`define BFX_IW_AD_LO 6
`define BFX_IW_BIT_HI 2

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define BFX_OFS_CTRL 12'h000
`define BFX_OFS_FLAGS 12'h004
`define BFX_OFS_COUNT 12'h008
`define BFX_REGION_GPR 4'h1
`define BFX_REGION_IO 4'h2
`define BFX_CTRL_RUN 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define BFX_FLAGS_RST 8'h00
`define BFX_CTRL_RST 1'b0
`define BFX_IO_OP_CYCLES 2

`endif

// File: core/bfx_pkg.sv
// types of the bit and flag operation executor
package bfx_pkg;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_IO_BIT_FORCE_ONE,
    OP_IO_BIT_FORCE_ZERO,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_COPY_REG_BIT_TO_TRANSFER_FLAG,
    OP_COPY_TRANSFER_FLAG_TO_REG_BIT,
    OP_FLAG_ASSERT,
    OP_FLAG_DEASSERT
  } bfx_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_IO_WB
  } bfx_state_t;

endpackage

// File: core/bfx_rot.sv
// rotate-through-carry datapath
`timescale 1ns/1ps
module bfx_rot (
  bfx_alu_if.rot alu
);
  assign alu.rol_res = {alu.opnd[6:0], alu.carry_in}; // RULE3
  assign alu.rol_c = alu.opnd[7]; // RULE3
  assign alu.ror_res = {alu.carry_in, alu.opnd[7:1]}; // RULE4
  assign alu.ror_c = alu.opnd[0]; // RULE4
endmodule // bfx_rot

// File: core/bfx_top.sv
// bit and flag operation executor with apb register access
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "bfx_defs.svh"
module bfx_top import bfx_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int NUM_GPR = 32,
  parameter int NUM_IO = 64,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] gpr_mem [NUM_GPR];
  logic [7:0] io_mem [NUM_IO];
  logic [7:0] flags_reg;
  logic run_reg;
  logic [CNT_W-1:0] count_reg;
  bfx_state_t state_reg;
  bfx_op_t io_op_reg;
  logic [5:0] io_addr_reg;
  logic [2:0] io_bit_reg;
  logic ready_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  bfx_op_t op;
  logic [4:0] rg_addr;
  logic [5:0] io_addr;
  logic [2:0] bit_idx;
  logic accept;
  logic io_accept;
  assign op = bfx_op_t'(instr_i[`BFX_IW_OP_HI:`BFX_IW_OP_LO]);
  assign rg_addr = instr_i[`BFX_IW_RG_HI:`BFX_IW_AD_LO];
  assign io_addr = instr_i[`BFX_IW_IO_HI:`BFX_IW_AD_LO];
  assign bit_idx = instr_i[`BFX_IW_BIT_HI:0];
  // ready is low only in the first cycle after reset and during the io write-back, so accept never collides with it
  assign accept = instr_valid_i & ready_reg & run_reg;
  assign io_accept = accept && (op == OP_IO_BIT_FORCE_ONE || op == OP_IO_BIT_FORCE_ZERO);

  // ----------------------------------------------------------------
  // datapath units
  // ----------------------------------------------------------------
  bfx_alu_if alu ();
  assign alu.opnd = (state_reg == ST_IO_WB) ? io_mem[io_addr_reg] : gpr_mem[rg_addr];
  assign alu.bit_sel = (state_reg == ST_IO_WB) ? io_bit_reg : bit_idx;
  assign alu.carry_in = flags_reg[`BFX_FLAG_C];
  assign alu.t_in = flags_reg[`BFX_FLAG_T];
  bfx_rot u_rot (.alu(alu));
  bfx_bitu u_bitu (.alu(alu));

  // ----------------------------------------------------------------
  // single-cycle execution
  // ----------------------------------------------------------------
  logic [7:0] flags_next;
  logic gpr_we;
  logic [7:0] gpr_next;
  always_comb begin
    flags_next = flags_reg; // RULE10
    gpr_we = 1'b0;
    gpr_next = alu.opnd;
    case (op)
      OP_ROTATE_LEFT_VIA_CARRY: begin
        gpr_we = 1'b1;
        gpr_next = alu.rol_res; // RULE3
        flags_next[`BFX_FLAG_C] = alu.rol_c;
        flags_next[`BFX_FLAG_Z] = ~|alu.rol_res;
        flags_next[`BFX_FLAG_N] = alu.rol_res[7];
        flags_next[`BFX_FLAG_V] = alu.rol_res[7] ^ alu.rol_c;
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        gpr_we = 1'b1;
        gpr_next = alu.ror_res; // RULE4
        flags_next[`BFX_FLAG_C] = alu.ror_c;
        flags_next[`BFX_FLAG_Z] = ~|alu.ror_res;
        flags_next[`BFX_FLAG_N] = alu.ror_res[7];
        flags_next[`BFX_FLAG_V] = alu.ror_res[7] ^ alu.ror_c;
      end
      OP_COPY_REG_BIT_TO_TRANSFER_FLAG: begin
        flags_next[`BFX_FLAG_T] = alu.ext_bit; // RULE5
      end
      OP_COPY_TRANSFER_FLAG_TO_REG_BIT: begin
        gpr_we = 1'b1;
        gpr_next = alu.ins_res; // RULE6
      end
      OP_FLAG_ASSERT: begin
        flags_next[bit_idx] = 1'b1; // RULE7 RULE8 RULE9
      end
      OP_FLAG_DEASSERT: begin
        flags_next[bit_idx] = 1'b0; // RULE7 RULE8 RULE9
      end
      default: flags_next = flags_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_access;
  logic apb_done;
  logic [3:0] region;
  logic [31:0] rd_data;
  logic addr_err;
  assign apb_access = psel_i & penable_i;
  assign apb_done = apb_access & pready_reg;
  assign region = paddr_i[11:8];
  always_comb begin
    rd_data = 32'h00000000;
    addr_err = 1'b0;
    if (paddr_i[1:0] != 2'b00) begin
      addr_err = 1'b1;
    end else if (region == `BFX_REGION_GPR && paddr_i[7] == 1'b0) begin
      rd_data = {24'h000000, gpr_mem[paddr_i[6:2]]};
      addr_err = pwrite_i & run_reg;
    end else if (region == `BFX_REGION_IO) begin
      rd_data = {24'h000000, io_mem[paddr_i[7:2]]};
      addr_err = pwrite_i & run_reg;
    end else if (paddr_i == `BFX_OFS_CTRL) begin
      rd_data = {31'h00000000, run_reg};
    end else if (paddr_i == `BFX_OFS_FLAGS) begin
      rd_data = {24'h000000, flags_reg};
      // live state is not writable while running
      addr_err = pwrite_i & run_reg;
    end else if (paddr_i == `BFX_OFS_COUNT) begin
      rd_data = 32'(count_reg);
      addr_err = pwrite_i;
    end else begin
      addr_err = 1'b1;
    end
  end

  logic apb_wr;
  assign apb_wr = apb_done & pwrite_i & ~pslverr_reg & pstrb_i[0];

  // ----------------------------------------------------------------
  // apb response, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= apb_access & ~pready_reg;
      if (apb_access & ~pready_reg) begin
        pslverr_reg <= addr_err;
        prdata_reg <= (pwrite_i | addr_err) ? 32'h00000000 : rd_data;
      end else begin
        pslverr_reg <= 1'b0;
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= `BFX_CTRL_RST;
    end else if (apb_wr && paddr_i == `BFX_OFS_CTRL) begin
      run_reg <= pwdata_i[`BFX_CTRL_RUN];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if ((accept && !io_accept && op <= OP_FLAG_DEASSERT)
                 || state_reg == ST_IO_WB) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // io sequencer: latch address and bit in the first cycle, read and write back in the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
      io_op_reg <= OP_NOP;
      io_addr_reg <= 6'h00;
      io_bit_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          ready_reg <= 1'b1;
          if (io_accept) begin
            state_reg <= ST_IO_WB; // RULE1 RULE2
            ready_reg <= 1'b0;
            io_op_reg <= op;
            io_addr_reg <= io_addr;
            io_bit_reg <= bit_idx;
          end
        end
        ST_IO_WB: begin
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // architectural storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `BFX_FLAGS_RST;
    end else if (accept) begin
      flags_reg <= flags_next; // RULE10
    end else if (apb_wr && paddr_i == `BFX_OFS_FLAGS) begin
      flags_reg <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_mem[i] <= 8'h00;
      end
    end else if (accept && gpr_we) begin
      gpr_mem[rg_addr] <= gpr_next; // RULE10
    end else if (apb_wr && region == `BFX_REGION_GPR) begin
      gpr_mem[paddr_i[6:2]] <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_IO; i++) begin
        io_mem[i] <= 8'h00;
      end
    end else if (state_reg == ST_IO_WB) begin
      io_mem[io_addr_reg] <= (io_op_reg == OP_IO_BIT_FORCE_ONE) ? alu.set_res
                                                                 : alu.clr_res; // RULE1 RULE2
    end else if (apb_wr && region == `BFX_REGION_IO) begin
      io_mem[paddr_i[7:2]] <= pwdata_i[7:0];
    end
  end

  assign instr_ready_o = ready_reg;
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  sequence s_io_two;
    !instr_ready_o ##1 instr_ready_o;
  endsequence
  property p_io_one;
    accept && op == OP_IO_BIT_FORCE_ONE |-> ##1 s_io_two
      ##0 (io_mem[$past(io_addr, 2)][$past(bit_idx, 2)] && flags_reg == $past(flags_reg, 2));
  endproperty
  a_io_one: assert property (p_io_one) else $error("io force-one wrong"); // RULE1
  property p_io_zero;
    accept && op == OP_IO_BIT_FORCE_ZERO |-> ##1 s_io_two
      ##0 (!io_mem[$past(io_addr, 2)][$past(bit_idx, 2)] && flags_reg == $past(flags_reg, 2));
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("io force-zero wrong"); // RULE2
  property p_rol;
    accept && op == OP_ROTATE_LEFT_VIA_CARRY |=>
      gpr_mem[$past(rg_addr)] == {$past(gpr_mem[rg_addr][6:0]), $past(flags_reg[0])}
      && flags_reg[`BFX_FLAG_C] == $past(gpr_mem[rg_addr][7]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong"); // RULE3
  property p_ror;
    accept && op == OP_ROTATE_RIGHT_VIA_CARRY |=>
      gpr_mem[$past(rg_addr)] == {$past(flags_reg[0]), $past(gpr_mem[rg_addr][7:1])}
      && flags_reg[`BFX_FLAG_C] == $past(gpr_mem[rg_addr][0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong"); // RULE4
  property p_bst;
    accept && op == OP_COPY_REG_BIT_TO_TRANSFER_FLAG |=>
      flags_reg == (($past(flags_reg) & 8'hBF) | {1'b0, $past(gpr_mem[rg_addr][bit_idx]), 6'h00});
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong"); // RULE5
  property p_bld;
    accept && op == OP_COPY_TRANSFER_FLAG_TO_REG_BIT |=>
      gpr_mem[$past(rg_addr)][$past(bit_idx)] == $past(flags_reg[6])
      && flags_reg == $past(flags_reg);
  endproperty
  a_bld: assert property (p_bld) else $error("bit load wrong"); // RULE6
  property p_flag_op;
    accept && (op == OP_FLAG_ASSERT || op == OP_FLAG_DEASSERT) |=>
      flags_reg[$past(bit_idx)] == ($past(op) == OP_FLAG_ASSERT)
      && ((flags_reg ^ $past(flags_reg)) & ~(8'h01 << $past(bit_idx))) == 8'h00;
  endproperty
  a_flag_op: assert property (p_flag_op) else $error("flag op wrong"); // RULE7 RULE8 RULE9
  property p_keep_i;
    accept && !(op == OP_FLAG_ASSERT || op == OP_FLAG_DEASSERT) |=>
      flags_reg[`BFX_FLAG_I] == $past(flags_reg[`BFX_FLAG_I])
      && flags_reg[`BFX_FLAG_H] == $past(flags_reg[`BFX_FLAG_H]);
  endproperty
  a_keep_i: assert property (p_keep_i) else $error("foreign flag changed"); // RULE10

endmodule // bfx_top

// File: tb/bfx_imem_model.sv
// program memory model handing instruction words to the executor
`timescale 1ns/1ps
module bfx_imem_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic instr_ready_i,
  output logic [15:0] instr_o,
  output logic instr_valid_o
);
  logic [15:0] words[$];
  int gap = 0;
  int gap_left = 0;
  int busy_cycles = 0;

  initial begin
    instr_o = 16'h0000;
    instr_valid_o = 1'b0;
  end

  task automatic push(input logic [15:0] w);
    words.push_back(w);
  endtask

  // ----------------------------------------------------------------
  // hand-over; idle word toggles so a stale word never looks valid
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      instr_valid_o <= 1'b0;
    end else begin
      if (instr_valid_o) begin
        busy_cycles++;
      end
      if (instr_valid_o && instr_ready_i) begin
        void'(words.pop_front());
        gap_left = gap;
      end
      if (instr_valid_o && !instr_ready_i) begin
        instr_o <= instr_o;
      end else if (gap_left == 0 && words.size() > 0) begin
        instr_o <= words[0];
        instr_valid_o <= 1'b1;
      end else begin
        if (gap_left > 0) begin
          gap_left--;
        end
        instr_o <= ~instr_o;
        instr_valid_o <= 1'b0;
      end
    end
  end
endmodule // bfx_imem_model

// File: tb/tb_bfx_top.sv
// self-checking bench for the bit and flag operation executor
`timescale 1ns/1ps
module tb_bfx_top;
  logic clk_i;
  logic rstn_i;
  logic [15:0] instr;
  logic instr_valid;
  logic instr_ready_o;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] gpr [32];
  logic [7:0] io [64];
  logic [7:0] flg;
  logic [15:0] cnt;
  logic run;

  bfx_top bfx_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr),
    .instr_valid_i(instr_valid), .instr_ready_o(instr_ready_o), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

  bfx_imem_model bfx_imem_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .instr_ready_i(instr_ready_o), .instr_o(instr), .instr_valid_o(instr_valid));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // compare, apb access and expected-state tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    check({31'h0, pready_o}, 32'h1);
    rdat = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] rdat;
    logic err;
    apb(1'b1, a, d, rdat, err);
    check({31'h0, err}, {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
    logic [31:0] rdat;
    logic err;
    apb(1'b0, a, 32'h0, rdat, err);
    check({31'h0, err}, {31'h0, e});
    if (!e) begin
      check(rdat, x);
    end
  endtask

  task automatic pre(input int k, input int n, input logic [7:0] v);
    wr(12'(k * 256 + 4 * n + (k == 0 ? 4 : 0)), {24'h0, v}, 1'b0);
    case (k)
      0: flg = v;
      1: gpr[n] = v;
      default: io[n] = v;
    endcase
  endtask

  task automatic set_run(input logic v);
    wr(12'h000, {31'h0, v}, 1'b0);
    run = v;
  endtask

  // expected effect is applied in issue order, so no design output is needed
  task automatic op(input logic [3:0] o, input logic [5:0] a, input logic [2:0] b);
    logic [7:0] r;
    logic c;
    r = gpr[a[4:0]];
    c = flg[0];
    bfx_imem_model_inst.push({o, a, 3'b000, b});
    if (run && o <= 4'h8) begin
      cnt++;
      case (o)
        4'h1: io[a][b] = 1'b1;
        4'h2: io[a][b] = 1'b0;
        4'h3, 4'h4: begin
          gpr[a[4:0]] = (o == 4'h3) ? {r[6:0], c} : {c, r[7:1]};
          flg[0] = (o == 4'h3) ? r[7] : r[0];
          flg[1] = (gpr[a[4:0]] == 8'h00);
          flg[2] = gpr[a[4:0]][7];
          flg[3] = flg[2] ^ flg[0];
        end
        4'h5: flg[6] = r[b];
        4'h6: gpr[a[4:0]][b] = flg[6];
        4'h7: flg[b] = 1'b1;
        4'h8: flg[b] = 1'b0;
        default: ;
      endcase
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((bfx_imem_model_inst.words.size() > 0 || instr_valid === 1'b1) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
  endtask

  task automatic check_state();
    rd(12'h004, {24'h0, flg}, 1'b0);
    rd(12'h008, {16'h0, cnt}, 1'b0);
    for (int n = 0; n < 32; n++) begin
      rd(12'h100 + 12'(4 * n), {24'h0, gpr[n]}, 1'b0);
    end
    for (int n = 0; n < 64; n++) begin
      rd(12'h200 + 12'(4 * n), {24'h0, io[n]}, 1'b0);
    end
  endtask

  task automatic final_report();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    run = 1'b0;
    flg = 8'h00;
    cnt = 16'h0000;
    for (int n = 0; n < 32; n++) gpr[n] = 8'h00;
    for (int n = 0; n < 64; n++) io[n] = 8'h00;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(12'h000, 32'h0, 1'b0);
    check_state();
    rd(12'h300, 32'h0, 1'b1);
    rd(12'h001, 32'h0, 1'b1);
    rd(12'h180, 32'h0, 1'b1);
    wr(12'h008, 32'h1, 1'b1);
    $display("test reset_and_map done");
    pre(0, 0, 8'hA5);
    pre(2, 0, 8'h5A);
    pre(2, 20, 8'hFF);
    pre(1, 0, 8'h33);
    set_run(1'b1);
    bfx_imem_model_inst.busy_cycles = 0;
    op(1, 0, 0);
    op(1, 0, 7);
    op(2, 20, 0);
    op(2, 20, 7);
    op(1, 63, 3);
    op(2, 0, 1);
    op(8, 0, 2);
    drain();
    check(32'(bfx_imem_model_inst.busy_cycles), 32'd13);
    set_run(1'b0);
    rd(12'h200, 32'hD9, 1'b0);
    rd(12'h250, 32'h7E, 1'b0);
    check_state();
    $display("test io_force done");
    pre(0, 0, 8'h00);
    pre(1, 1, 8'h80);
    pre(1, 2, 8'h01);
    pre(1, 31, 8'hC3);
    set_run(1'b1);
    bfx_imem_model_inst.gap = 1;
    bfx_imem_model_inst.busy_cycles = 0;
    op(3, 1, 0);
    op(4, 2, 0);
    op(3, 31, 0);
    op(4, 5, 0);
    op(3, 5, 0);
    for (int b = 0; b < 8; b++) begin
      op(7, 0, 3'(b));
      op(5, 31, 3'(b));
      op(6, 5, 3'(b));
      if (b % 2 == 1) op(8, 0, 3'(b));
    end
    drain();
    check(32'(bfx_imem_model_inst.busy_cycles), 32'd33);
    set_run(1'b0);
    rd(12'h104, 32'h00, 1'b0);
    rd(12'h108, 32'h80, 1'b0);
    check_state();
    $display("test rotate_bit_flag done");
    bfx_imem_model_inst.gap = 0;
    // byte lane 0 off: write is answered but must leave the register alone
    pstrb <= 4'h0;
    wr(12'h100, 32'h77, 1'b0);
    pstrb <= 4'hF;
    set_run(1'b1);
    wr(12'h004, 32'hFF, 1'b1);
    wr(12'h100, 32'h11, 1'b1);
    wr(12'h200, 32'h11, 1'b1);
    op(9, 0, 0);
    op(15, 1, 1);
    op(8, 0, 6);
    drain();
    set_run(1'b0);
    op(1, 0, 2);
    drain();
    check_state();
    $display("test refusals done");
    final_report();
  end

  initial begin
    #(20 * 40000);
    mismatches++;
    final_report();
  end
endmodule // tb_bfx_top
